// ---- hdl/cse_ctrl.sv ----
// Quarter unit control: registers, initialization and readout FIFOs, monitor ADC.
`default_nettype none
// Operation
// R1: Four selects: config, monitor, FIFO pairs.
// R2: Select lines active low, thirty per terminal.
// R3: Subaddress placement chosen per block by parameters.
// R4: Config holds counts and output modes.
// R5: Monitor register channel, start, valid, result, resets.
// R6: Channel codes map to string supplies, ground.
// R7: Mode 00 at strobe fall enters initialization.
// R8: Capture chip count times 190 bits.
// R9: Output mode picks serial return or bus.
// R10: Counts reset to 3, modes to 0.
// R11: Config write resets both initialization FIFOs.
// R12: Host writes config outside initialization mode.
// R13: Readout word: byte low, marker bit 8.
// R14: Third marker word ends the event.
// R15: Readout FIFO depth 4K words.
// R16: Readout mode sends bytes with strobe.
// R17: Stop at event end until mode redeclared.
// R18: Readout data kept for replay.
// R19: Bits 13, 14 reset readout FIFOs.
// R20: Start launches conversion, clears start, result.
// R21: Completion loads result and valid together.
// R22: Host polls valid before using result.
// R23: Readout mode decoded at strobe fall.
// R24: Unused bits read zero, ignore writes.
module cse_ctrl
  import cse_pkg::*;
#(
  parameter bit          SELECT_TERMINAL   = 1'b0,
  parameter int unsigned SELECT_BASE       = SUBAD_SPLIT,
  parameter logic [1:0]  READOUT_MODE_CODE = MODE_READOUT_DEF
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [29:0]      firstTerminalSelectLinesN,
  input  wire logic [29:0]      secondTerminalSelectLinesN,
  input  wire logic             transmit,
  input  wire logic [15:0]      busDataIn,
  output logic      [15:0]      busDataOut,
  output logic                  busDataOutEn,
  input  wire logic [1:0]       modeLines,
  input  wire logic             modeChangeStrobe,
  input  wire logic             serialClock,
  input  wire logic [1:0]       serialDataIn,
  output logic      [1:0]       serialDataOut,
  output logic      [1:0][7:0]  readoutData,
  output logic      [1:0]       readoutByteStrobe,
  output logic                  adcStart,
  output logic      [2:0]       adcChannel,
  input  wire logic             adcDone,
  input  wire logic [7:0]       adcResult
);

  if (SELECT_BASE < 1 || SELECT_BASE + SEL_COUNT - 1 > SUBAD_LAST) begin : gBadBase
    $error("Select base does not leave four subaddresses on the terminal.");
  end

  if (READOUT_MODE_CODE == MODE_INIT) begin : gBadMode
    $error("Readout mode code collides with the initialization code.");
  end

  if (RO_DEPTH != 2 ** RO_PTR_W) begin : gBadDepth
    $error("Readout depth does not match its pointer width.");
  end

  if (2 ** INIT_PTR_W != INIT_WORDS * WORD_W) begin : gBadInitPtr
    $error("Initialization pointer does not span the initialization store.");
  end

  if (INIT_WORDS * WORD_W < (2 ** CNT_W - 1) * int'(BITS_PER_CHIP)) begin : gBadInit
    $error("Initialization store cannot hold the longest stream.");
  end

  if (RO_MARK_BIT >= RO_W || RO_W > WORD_W) begin : gBadMark
    $error("Readout word does not fit the bus word.");
  end

  typedef struct packed {
    logic [3:0]                  selM;
    logic [3:0]                  selS;
    logic [3:0]                  selP;
    logic                        txM;
    logic                        txS;
    logic [15:0]                 dinM;
    logic [15:0]                 dinS;
    logic [1:0]                  modeM;
    logic [1:0]                  modeS;
    logic                        chgM;
    logic                        chgS;
    logic                        chgP;
    logic                        sclkM;
    logic                        sclkS;
    logic                        sclkP;
    logic [1:0]                  sinM;
    logic [1:0]                  sinS;
    logic                        doneM;
    logic                        doneS;
    logic                        doneP;
    logic [7:0]                  resM;
    logic [7:0]                  resS;
    logic [1:0][CNT_W-1:0]       cnt;
    logic [1:0]                  outMode;
    logic [CHAN_W-1:0]           chan;
    logic                        start;
    logic                        valid;
    logic [RES_W-1:0]            result;
    logic                        initMode;
    logic                        readMode;
    logic [1:0][INIT_PTR_W-1:0]  iWr;
    logic [1:0][INIT_PTR_W-1:0]  iRd;
    logic [1:0][RO_PTR_W:0]      rWr;
    logic [1:0][RO_PTR_W-1:0]    rRd;
    logic [1:0][1:0]             marks;
    logic [1:0]                  play;
    logic [15:0]                 dout;
    logic                        doutEn;
    logic [1:0]                  serOut;
    logic [1:0][7:0]             roData;
    logic [1:0]                  roStrobe;
    logic                        adcGo;
    logic [CHAN_W-1:0]           adcChan;
  } cse_state_t;

  cse_state_t q;
  cse_state_t d;

  logic [3:0]                 selPins;
  logic [1:0]                 iWe;
  logic [1:0]                 rWe;
  logic [1:0][WORD_W-1:0]     iWord;
  logic [1:0][RO_W-1:0]       rWord;
  logic [1:0][INIT_PTR_W-1:0] target;

  // The quarter unit's four consecutive subaddress selects on the chosen terminal.
  assign selPins = SELECT_TERMINAL ? secondTerminalSelectLinesN[SELECT_BASE-1 +: SEL_COUNT]
                                   : firstTerminalSelectLinesN[SELECT_BASE-1 +: SEL_COUNT]; // R3

  for (genvar s = 0; s < 2; s++) begin : gStr
    logic [WORD_W-1:0] iMem [INIT_WORDS];
    logic [RO_W-1:0]   rMem [RO_DEPTH];

    // Initialization bits are stored one at a time and read back as whole words.
    always_ff @(posedge clk) begin
      if (iWe[s]) begin
        iMem[q.iWr[s][INIT_PTR_W-1:4]][q.iWr[s][3:0]] <= q.sinS[s];
      end
      if (rWe[s]) begin
        rMem[q.rWr[s][RO_PTR_W-1:0]] <= q.dinS[RO_W-1:0]; // R13
      end
    end

    assign iWord[s]  = iMem[q.iRd[s][INIT_PTR_W-1:4]];
    assign rWord[s]  = rMem[q.rRd[s]];
    assign target[s] = INIT_PTR_W'(q.cnt[s]) * BITS_PER_CHIP; // R8
  end

  always_comb begin
    logic [3:0] selFall;
    logic       chgFall;
    logic       sclkRise;
    logic       full;
    selFall  = q.selP & ~q.selS;
    chgFall  = q.chgP & ~q.chgS;
    sclkRise = q.sclkS & ~q.sclkP;
    full     = 1'b0;
    d        = q;
    iWe      = 2'h0;
    rWe      = 2'h0;

    // Two flip-flops on every pin before any logic looks at it.
    d.selM  = selPins;
    d.selS  = q.selM;
    d.selP  = q.selS;
    d.txM   = transmit;
    d.txS   = q.txM;
    d.dinM  = busDataIn;
    d.dinS  = q.dinM;
    d.modeM = modeLines;
    d.modeS = q.modeM;
    d.chgM  = modeChangeStrobe;
    d.chgS  = q.chgM;
    d.chgP  = q.chgS;
    d.sclkM = serialClock;
    d.sclkS = q.sclkM;
    d.sclkP = q.sclkS;
    d.sinM  = serialDataIn;
    d.sinS  = q.sinM;
    d.doneM = adcDone;
    d.doneS = q.doneM;
    d.doneP = q.doneS;
    d.resM  = adcResult;
    d.resS  = q.resM;

    d.roStrobe = 2'h0;
    d.adcGo    = 1'b0;
    d.doutEn   = (|(~q.selS)) & q.txS; // R2

    // Mode lines are judged only at the falling edge of the mode-change strobe.
    if (chgFall) begin
      d.initMode = (q.modeS == MODE_INIT); // R7
      d.readMode = (q.modeS == READOUT_MODE_CODE); // R23
      if (q.modeS == MODE_INIT && !q.initMode) begin
        d.iWr = '0; // R7
        d.iRd = '0;
      end
      if (q.modeS == READOUT_MODE_CODE) begin
        d.play = 2'h3; // R16
      end else begin
        d.play = 2'h0; // R17
      end
    end

    for (int s = 0; s < 2; s++) begin
      // Serial capture of exactly the programmed length, then optional serial return.
      if (q.initMode && sclkRise) begin
        if (q.iWr[s] < target[s]) begin
          iWe[s]   = 1'b1; // R8
          d.iWr[s] = q.iWr[s] + INIT_PTR_W'(1);
        end else if (q.outMode[s] == OUT_MODE_SER && q.iRd[s] < target[s]) begin
          d.serOut[s] = iWord[s][q.iRd[s][3:0]]; // R9
          d.iRd[s]    = q.iRd[s] + INIT_PTR_W'(1);
        end
      end

      // Event playout, one byte per cycle, stopping after the third consecutive marker word.
      if (q.play[s]) begin
        if ({1'b0, q.rRd[s]} < q.rWr[s]) begin
          d.roData[s]   = rWord[s][7:0];
          d.roStrobe[s] = 1'b1; // R16
          d.rRd[s]      = q.rRd[s] + RO_PTR_W'(1);
          d.marks[s]    = rWord[s][RO_MARK_BIT] ? q.marks[s] + 2'h1 : 2'h0;
          if (rWord[s][RO_MARK_BIT] && q.marks[s] == RO_LAST_MARK) begin
            d.play[s]  = 1'b0; // R14
            d.marks[s] = 2'h0;
          end
        end else begin
          d.rRd[s]   = '0; // R18
          d.marks[s] = 2'h0;
          d.play[s]  = 1'b0;
        end
      end

      // A readout declaration in the same cycle as an event end still starts playout.
      if (chgFall && q.modeS == READOUT_MODE_CODE) begin
        d.play[s] = 1'b1; // R23
      end

      // Bus access to this string's FIFO pair.
      if (selFall[SEL_FIFO_ONE + s]) begin
        if (q.txS) begin
          d.dout = 16'h0000;
          if (q.outMode[s] != OUT_MODE_SER && q.iWr[s] == target[s] && q.iRd[s] < target[s]) begin
            d.dout   = iWord[s]; // R9
            d.iRd[s] = q.iRd[s] + INIT_PTR_W'(WORD_W);
          end
        end else begin
          full = (q.rWr[s] == (RO_PTR_W + 1)'(RO_DEPTH)); // R15
          if (!full) begin
            rWe[s]   = 1'b1; // R1
            d.rWr[s] = q.rWr[s] + (RO_PTR_W + 1)'(1);
          end
        end
      end
    end

    // A pending start launches the conversion one cycle after the write.
    if (q.start) begin
      d.adcGo   = 1'b1; // R20
      d.adcChan = q.chan; // R6
      d.start   = 1'b0;
      d.valid   = 1'b0;
      d.result  = '0;
    end
    if (q.doneS && !q.doneP && !q.start) begin
      d.result = q.resS; // R21
      d.valid  = 1'b1;
    end

    // String configuration register.
    if (selFall[SEL_CFG]) begin
      if (q.txS) begin
        d.dout = 16'h0000; // R24
        d.dout[CFG_CNT_LSB0 +: CNT_W] = q.cnt[0]; // R4
        d.dout[CFG_MODE_BIT0]          = q.outMode[0];
        d.dout[CFG_CNT_LSB1 +: CNT_W] = q.cnt[1];
        d.dout[CFG_MODE_BIT1]          = q.outMode[1];
      end else begin
        d.cnt[0]     = q.dinS[CFG_CNT_LSB0 +: CNT_W]; // R4
        d.outMode[0] = q.dinS[CFG_MODE_BIT0];
        d.cnt[1]     = q.dinS[CFG_CNT_LSB1 +: CNT_W];
        d.outMode[1] = q.dinS[CFG_MODE_BIT1];
        d.iWr        = '0; // R11
        d.iRd        = '0;
      end
    end

    // Monitor and readout FIFO control register.
    if (selFall[SEL_MON]) begin
      if (q.txS) begin
        d.dout = 16'h0000; // R24
        d.dout[MON_CHAN_LSB +: CHAN_W] = q.chan; // R5
        d.dout[MON_START_BIT]          = q.start;
        d.dout[MON_VALID_BIT]          = q.valid;
        d.dout[MON_RES_LSB +: RES_W]   = q.result;
      end else begin
        d.chan = q.dinS[MON_CHAN_LSB +: CHAN_W]; // R5
        if (q.dinS[MON_START_BIT]) begin
          d.start = 1'b1; // R20
        end
        for (int s = 0; s < 2; s++) begin
          if (q.dinS[s == 0 ? MON_RST_BIT0 : MON_RST_BIT1]) begin
            d.rWr[s]   = '0; // R19
            d.rRd[s]   = '0;
            d.marks[s] = 2'h0;
            d.play[s]  = 1'b0;
            rWe[s]     = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q         <= '0;
      q.selM    <= 4'hf;
      q.selS    <= 4'hf;
      q.selP    <= 4'hf;
      q.cnt     <= {CHIP_COUNT_RST, CHIP_COUNT_RST}; // R10
      q.outMode <= {OUT_MODE_RST, OUT_MODE_RST};
    end else begin
      q <= d;
    end
  end

  assign busDataOut        = q.dout;
  assign busDataOutEn      = q.doutEn;
  assign serialDataOut     = q.serOut;
  assign readoutData       = q.roData;
  assign readoutByteStrobe = q.roStrobe;
  assign adcStart          = q.adcGo;
  assign adcChannel        = q.adcChan;

endmodule : cse_ctrl
`default_nettype wire

// ---- pkg/cse_pkg.sv ----
// Constants shared by the string emulator control quarter unit.
`default_nettype none
package cse_pkg;
  // Select lines within the four consecutive subaddresses of one quarter unit.
  localparam int unsigned SEL_CFG        = 0;
  localparam int unsigned SEL_MON        = 1;
  localparam int unsigned SEL_FIFO_ONE   = 2;
  localparam int unsigned SEL_COUNT      = 4;
  localparam int unsigned SUBAD_SPLIT    = 20;
  localparam int unsigned SUBAD_BLOCK_B  = 24;
  localparam int unsigned SUBAD_BLOCK_D  = 27;
  localparam int unsigned SUBAD_LAST     = 30;

  // String configuration register fields.
  localparam int unsigned CFG_CNT_LSB0   = 0;
  localparam int unsigned CFG_MODE_BIT0  = 5;
  localparam int unsigned CFG_CNT_LSB1   = 6;
  localparam int unsigned CFG_MODE_BIT1  = 11;
  localparam int unsigned CNT_W          = 5;
  localparam logic [4:0]  CHIP_COUNT_RST = 5'h03;
  localparam logic        OUT_MODE_RST   = 1'h0;
  localparam logic        OUT_MODE_SER   = 1'h0;

  // Monitor and FIFO control register fields.
  localparam int unsigned MON_CHAN_LSB   = 0;
  localparam int unsigned CHAN_W         = 3;
  localparam int unsigned MON_START_BIT  = 3;
  localparam int unsigned MON_VALID_BIT  = 4;
  localparam int unsigned MON_RES_LSB    = 5;
  localparam int unsigned RES_W          = 8;
  localparam int unsigned MON_RST_BIT0   = 13;
  localparam int unsigned MON_RST_BIT1   = 14;

  // Monitor channel codes.
  localparam logic [2:0] CH_S1_ANALOG_TWO = 3'h0;
  localparam logic [2:0] CH_S1_ANALOG_ONE = 3'h1;
  localparam logic [2:0] CH_S1_DIGITAL    = 3'h2;
  localparam logic [2:0] CH_S2_ANALOG_TWO = 3'h3;
  localparam logic [2:0] CH_S2_ANALOG_ONE = 3'h4;
  localparam logic [2:0] CH_S2_DIGITAL    = 3'h5;
  localparam logic [2:0] CH_GROUND_A      = 3'h6;
  localparam logic [2:0] CH_GROUND_B      = 3'h7;

  // Sequencer mode codes.
  localparam logic [1:0] MODE_INIT        = 2'h0;
  localparam logic [1:0] MODE_READOUT_DEF = 2'h3;

  // Initialization and readout storage.
  localparam logic [12:0] BITS_PER_CHIP   = 13'h00be;
  localparam int unsigned INIT_PTR_W      = 13;
  localparam int unsigned INIT_WORDS      = 512;
  localparam int unsigned WORD_W          = 16;
  localparam int unsigned RO_DEPTH        = 4096;
  localparam int unsigned RO_PTR_W        = 12;
  localparam int unsigned RO_W            = 9;
  localparam int unsigned RO_MARK_BIT     = 8;
  localparam logic [1:0]  RO_LAST_MARK    = 2'h2;
endpackage : cse_pkg
`default_nettype wire

// ---- sim/cse_adc_model.sv ----
// Behavioural model of the supply-monitor converter.
`default_nettype none
module cse_adc_model #(
  parameter int LAT = 30
) (
  input  wire logic       clk,
  input  wire logic       adcStart,
  input  wire logic [2:0] adcChannel,
  output logic            adcDone,
  output logic      [7:0] adcResult
);
  timeunit 1ns;
  timeprecision 1ps;
  int         cnt = 0;
  logic       doneQ = 1'b0;
  logic [7:0] resQ = 8'h00;
  assign adcDone = doneQ;
  assign adcResult = resQ;
  // The result settles four cycles before done rises.
  always @(posedge clk) begin
    if (adcStart) begin
      cnt <= 1;
      doneQ <= 1'b0;
    end else if (cnt > 0) begin
      cnt <= (cnt == LAT + 8) ? 0 : cnt + 1;
      if (cnt == LAT) resQ <= {5'h15, adcChannel};
      if (cnt == LAT + 4) doneQ <= 1'b1;
    end
  end
endmodule : cse_adc_model
`default_nettype wire

// ---- sim/cse_ctrl_asserts.sv ----
// Port-level checker of the quarter unit control.
`default_nettype none
module cse_ctrl_asserts (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [29:0] firstTerminalSelectLinesN,
  input wire logic        transmit,
  input wire logic [15:0] busDataIn,
  input wire logic [15:0] busDataOut,
  input wire logic        busDataOutEn,
  input wire logic [1:0]  modeLines,
  input wire logic        modeChangeStrobe,
  input wire logic [1:0]  readoutByteStrobe,
  input wire logic        adcStart,
  input wire logic [2:0]  adcChannel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  a_start_pulse:
    assert property (adcStart |=> !adcStart) else $error("Converter start longer than one cycle.");
  a_start_cause:
    assert property (adcStart |-> $past(busDataIn[3], 2) && adcChannel == $past(busDataIn[2:0], 2))
    else $error("Converter start without a matching write.");
  a_chan_hold:
    assert property (!adcStart |-> $stable(adcChannel)) else $error("Channel moved without a start.");
  a_en_write:
    assert property (!transmit [*4] |-> !busDataOutEn) else $error("Bus driven while receiving.");
  a_en_release:
    assert property ((&firstTerminalSelectLinesN[22:19]) [*4] |-> !busDataOutEn)
    else $error("Bus driven while unselected.");
  a_en_read:
    assert property ((transmit && !(&firstTerminalSelectLinesN[22:19])) [*5] |-> busDataOutEn)
    else $error("Bus not driven during a read.");
  a_dout_hold:
    assert property (!$stable(busDataOut) |-> busDataOutEn || $past(busDataOutEn))
    else $error("Read data changed outside a read.");
  a_play_stop:
    assert property ($fell(modeChangeStrobe) && modeLines != 2'h3 |-> ##5 (readoutByteStrobe == 2'h0) [*8])
    else $error("Bytes sent outside readout mode.");
  c_convert: cover property (adcStart);
  c_play: cover property (readoutByteStrobe[0]);
  c_read: cover property (busDataOutEn);
endmodule : cse_ctrl_asserts
`default_nettype wire

// ---- sim/cse_ctrl_tb.sv ----
// Self-checking bench of the quarter unit control.
`default_nettype none
module cse_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic            clk = 1'b0;
  logic            srst = 1'b1;
  logic [29:0]     selN = 30'h3fffffff;
  logic            transmit = 1'b0;
  logic [15:0]     din = 16'h0000;
  logic [15:0]     dout;
  logic            doutEn;
  logic [1:0]      mode = 2'h1;
  logic            chStrobe = 1'b1;
  logic            sClk = 1'b0;
  logic [1:0]      sIn = 2'h0;
  logic [1:0]      sOut;
  logic [1:0][7:0] roData;
  logic [1:0]      roStb;
  logic            adcStart;
  logic            adcDone;
  logic [2:0]      adcChannel;
  logic [7:0]      adcResult;
  logic [15:0]     rd;
  logic [15:0]     ex;
  logic [7:0]      got[$];
  int              nMismatch = 0;
  int              nChecks = 0;
  int              cyc = 0;
  int              nTwo = 0;
  logic [15:0]     rows [3][3] = '{'{16'h0014, 16'hffff, 16'h0fff}, '{16'h0014, 16'h0c09, 16'h0c09},
                                   '{16'h0015, 16'he005, 16'h0005}};
  logic [15:0]     ev [9] = '{16'h0011, 16'h0022, 16'h0133, 16'h0144, 16'h0155,
                              16'h0066, 16'h0177, 16'h0188, 16'h0199};

  cse_ctrl uut (.clk(clk), .srst(srst), .firstTerminalSelectLinesN(selN),
    .secondTerminalSelectLinesN(30'h3fffffff), .transmit(transmit), .busDataIn(din), .busDataOut(dout),
    .busDataOutEn(doutEn), .modeLines(mode), .modeChangeStrobe(chStrobe), .serialClock(sClk),
    .serialDataIn(sIn), .serialDataOut(sOut), .readoutData(roData), .readoutByteStrobe(roStb),
    .adcStart(adcStart), .adcChannel(adcChannel), .adcDone(adcDone), .adcResult(adcResult));
  cse_adc_model #(.LAT(30)) adc (.clk(clk), .adcStart(adcStart), .adcChannel(adcChannel),
    .adcDone(adcDone), .adcResult(adcResult));

  always #2.5 clk = ~clk;

  // Counts cycles against the ceiling, collects string one's bytes and counts string two's strobes.
  always @(negedge clk) begin
    cyc++;
    if (roStb[0] === 1'b1) got.push_back(roData[0]);
    if (roStb[1] !== 1'b0) nTwo++;
    if (cyc == 20000) begin
      nMismatch++;
      conclude();
    end
  end

  task automatic conclude();
    if (nMismatch == 0 && nChecks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    nChecks++;
    if (g !== e) begin
      nMismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic bus(input int sa, input logic tx, input logic [15:0] w);
    @(negedge clk);
    transmit = tx;
    din = w;
    @(negedge clk);
    selN[sa - 1] = 1'b0;
    repeat (8) @(negedge clk);
    rd = dout;
    selN = 30'h3fffffff;
    repeat (5) @(negedge clk);
  endtask : bus

  task automatic setMode(input logic [1:0] m);
    @(negedge clk);
    mode = m;
    chStrobe = 1'b1;
    repeat (4) @(negedge clk);
    chStrobe = 1'b0;
    repeat (20) @(negedge clk);
  endtask : setMode

  task automatic play(input int first, input int n);
    got.delete();
    setMode(2'h1);
    setMode(2'h3);
    chk(16'(got.size()), 16'(n));
    for (int k = 0; k < n; k++) chk({8'h00, got[k]}, {8'h00, ev[first + k][7:0]});
  endtask : play

  function automatic logic pat(input int i);
    return logic'(i % 3 == 0);
  endfunction : pat

  initial begin
    repeat (10) @(negedge clk);
    srst = 1'b0;
    bus(20, 1'b1, 16'h0000);
    chk(rd, 16'h00c3);
    bus(21, 1'b1, 16'h0000);
    chk(rd, 16'h0000);
    for (int r = 0; r < 3; r++) begin
      bus(int'(rows[r][0]), 1'b0, rows[r][1]);
      bus(int'(rows[r][0]), 1'b1, 16'h0000);
      chk(rd, rows[r][2]);
    end
    bus(20, 1'b0, 16'h0061);
    setMode(2'h0);
    for (int i = 0; i < 200; i++) begin
      sIn = {2{pat(i)}};
      repeat (4) @(negedge clk);
      sClk = 1'b1;
      repeat (8) @(negedge clk);
      sClk = 1'b0;
      repeat (4) @(negedge clk);
      if (i >= 190) chk({14'h0000, sOut}, {14'h0000, pat(i - 190), 1'b0});
    end
    for (int j = 0; j < 11; j++) begin
      bus(22, 1'b1, 16'h0000);
      for (int b = 0; b < 16; b++) ex[b] = pat(16 * j + b);
      chk(rd, ex);
    end
    setMode(2'h1);
    bus(20, 1'b0, 16'h0061);
    bus(22, 1'b1, 16'h0000);
    chk(rd, 16'h0000);
    bus(21, 1'b0, 16'h6000);
    for (int w = 0; w < 9; w++) bus(22, 1'b0, ev[w]);
    play(0, 5);
    play(5, 4);
    play(0, 0);
    play(0, 5);
    bus(21, 1'b0, 16'h2000);
    play(0, 0);
    for (int c = 0; c < 8; c++) begin
      bus(21, 1'b0, 16'(8 + c));
      rd = 16'h0000;
      for (int k = 0; k < 20 && rd[4] !== 1'b1; k++) bus(21, 1'b1, 16'h0000);
      chk(rd, {3'h0, 5'h15, 3'(c), 2'h2, 3'(c)});
    end
    chk(16'(nTwo), 16'h0000);
    conclude();
  end
endmodule : cse_ctrl_tb

bind cse_ctrl cse_ctrl_asserts u_chk (.clk(clk), .srst(srst), .firstTerminalSelectLinesN(firstTerminalSelectLinesN),
  .transmit(transmit), .busDataIn(busDataIn), .busDataOut(busDataOut), .busDataOutEn(busDataOutEn),
  .modeLines(modeLines), .modeChangeStrobe(modeChangeStrobe), .readoutByteStrobe(readoutByteStrobe),
  .adcStart(adcStart), .adcChannel(adcChannel));
`default_nettype wire
